// *** dv/lawdt_mcu_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module lawdt_mcu_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       run,
	input  wire logic [7:0] period,
	output logic            trig,
	output logic            driven
);
	logic [7:0] cnt_reg;

	// released level
	// Released pin sits at its pull-down level, never at the last driven value
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			cnt_reg <= 8'h00;
			trig    <= 1'b0;
			driven  <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg >= period - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
			trig    <= (cnt_reg < (period >> 1)); // Half-period high pulse
			driven  <= 1'b1;
		end
	end
endmodule // lawdt_mcu_model

`default_nettype wire

// *** dv/load_aware_watchdog_timer_test.sv ***
`timescale 1ns/100ps
`default_nettype none

module load_aware_watchdog_timer_test;
	import lawdt_pkg::*;

	logic                clk;
	logic                reset;
	logic                en, en_drv, adj_var, act, deact, sup, vrel, vdet, rst_o, run;
	logic [1:0]          adj;
	logic                trig, trig_drv, wdo, comb, mon, flag;
	lawdt_phase_t        phase;
	logic [2:0]          cyc;
	int                  error_cnt;
	int                  check_count;
	int                  n;

	// Short timing cycle: 4 + 4 clocks keeps timeouts fast
	lawdt_top #(.CHARGE_CYC(4), .DISCHARGE_CYC(4)) DUT (
		.clk(clk), .reset(reset), .watchdog_enable(en), .enable_pin_driven(en_drv),
		.watchdog_trigger_input(trig), .trigger_pin_driven(trig_drv), .adjust_variant(adj_var),
		.activation_mode_adjust_pin(adj), .activation_current_reached(act),
		.deactivation_current_reached(deact), .input_supply_ok(sup), .vout_at_release(vrel),
		.vout_at_detect(vdet), .reset_output(rst_o), .watchdog_output(wdo), .combined_output(comb),
		.monitoring_active(mon), .load_current_flag(flag), .timing_phase(phase),
		.completed_cycles(cyc)
	);

	lawdt_mcu_model mcu (
		.clk(clk), .reset(reset), .run(run), .period(8'h0C), .trig(trig), .driven(trig_drv)
	);

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Saturate a count to four bits so a wrap cannot pose as a match
	function automatic logic [3:0] sat4(input int v);
		return (v > 15) ? 4'hF : v[3:0];
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Pins pass a synchroniser, so give them time to land
	task automatic settle();
		repeat (10) @(negedge clk);
	endtask

	// Bounded wait for the watchdog output to fall
	task automatic wait_low(input int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			@(negedge clk);
			if (wdo === 1'b0) break;
		end
		check("timeout_seen", {3'h0, wdo}, 4'h0);
	endtask

	// Length of the low period; drop enable, or run triggers that must be ignored
	task automatic measure_low(input logic kill, output int len);
		len = 1;
		@(posedge clk);
		if (kill) begin
			en <= 1'b0;
		end else begin
			run <= 1'b1;
		end
		while (len < 40) begin
			@(negedge clk);
			if (wdo !== 1'b0) break;
			len++;
		end
	endtask

	// Hang guard, far beyond the planned run
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	// Main sequence
	initial begin
		error_cnt = 0;
		check_count = 0;
		reset = 1'b1; en = 1'b0; en_drv = 1'b1; adj_var = 1'b0; adj = 2'h0; act = 1'b0;
		deact = 1'b0; sup = 1'b1; vrel = 1'b1; vdet = 1'b0; rst_o = 1'b1; run = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check("wdo_rst", {3'h0, wdo}, 4'h1);
		check("comb_rst", {3'h0, comb}, 4'h0);
		check("phase_rst", {2'h0, phase}, {2'h0, LAWDT_IDLE});
		check("cyc_rst", {1'h0, cyc}, 4'h0);
		$display("test reset done");

		// Load flag hysteresis
		@(posedge clk); en <= 1'b1; act <= 1'b1; settle();
		check("flag_set", {3'h0, flag}, 4'h1);
		check("mon_on", {3'h0, mon}, 4'h1);
		@(posedge clk); act <= 1'b0; settle();
		check("flag_hold", {3'h0, flag}, 4'h1);
		@(posedge clk); deact <= 1'b1; settle();
		check("flag_clear", {3'h0, flag}, 4'h0);
		check("mon_off", {3'h0, mon}, 4'h0);
		@(posedge clk); deact <= 1'b0; settle();
		check("flag_stay_off", {3'h0, flag}, 4'h0);
		@(posedge clk); act <= 1'b1; settle();
		check("flag_again", {3'h0, flag}, 4'h1);
		$display("test hysteresis done");

		// Regular triggers keep the output high
		@(posedge clk); run <= 1'b1;
		n = 0;
		repeat (200) begin
			@(negedge clk);
			if (wdo !== 1'b1) n++;
		end
		check("no_timeout", sat4(n), 4'h0);
		@(posedge clk); run <= 1'b0;
		wait_low(60);
		check("comb_low", {3'h0, comb}, 4'h0);
		measure_low(1'b0, n);
		check("low_len", sat4(n), 4'h8);
		check("cyc_after", {1'h0, cyc}, 4'h0);
		@(posedge clk);
		run <= 1'b0;
		$display("test timeout done");

		// Drop out while high clears the count
		n = 0;
		while (cyc !== 3'h2 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("cyc_two", {1'h0, cyc}, 4'h2);
		@(posedge clk); en <= 1'b0; settle();
		check("cyc_clr", {1'h0, cyc}, 4'h0);
		check("phase_idle", {2'h0, phase}, {2'h0, LAWDT_IDLE});
		check("flag_dis", {3'h0, flag}, 4'h0);
		$display("test deactivate high done");

		// Drop out while low still finishes the low cycle
		@(posedge clk); en <= 1'b1; act <= 1'b1; settle();
		wait_low(60);
		measure_low(1'b1, n);
		check("low_len_kill", sat4(n), 4'h8);
		settle();
		check("wdo_back", {3'h0, wdo}, 4'h1);
		check("mon_dis", {3'h0, mon}, 4'h0);
		$display("test deactivate low done");

		// Floating enable, voltage gating, combined pin
		@(posedge clk); en <= 1'b1; en_drv <= 1'b0; settle();
		check("mon_float", {3'h0, mon}, 4'h0);
		@(posedge clk); en_drv <= 1'b1; rst_o <= 1'b0; settle();
		check("mon_en", {3'h0, mon}, 4'h1);
		check("comb_rst_lo", {3'h0, comb}, 4'h0);
		@(posedge clk); rst_o <= 1'b1; vdet <= 1'b1; settle();
		check("comb_both_hi", {3'h0, comb}, 4'h1);
		check("mon_vdet", {3'h0, mon}, 4'h0);
		@(posedge clk); vdet <= 1'b0; vrel <= 1'b0; settle();
		check("mon_vrel", {3'h0, mon}, 4'h0);
		@(posedge clk); vrel <= 1'b1; settle();
		$display("test gating done");

		// Low supply freezes the flag
		@(posedge clk); sup <= 1'b0; act <= 1'b0; deact <= 1'b1; settle();
		check("flag_frozen", {3'h0, flag}, 4'h1);
		@(posedge clk); sup <= 1'b1; settle();
		check("flag_thaw", {3'h0, flag}, 4'h0);
		$display("test supply done");

		// Adjust pin modes with the load flag low
		@(posedge clk); adj_var <= 1'b1; deact <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk); adj <= c[1:0]; settle();
			check("mon_adj", {3'h0, mon}, (c == 1) ? 4'h1 : 4'h0);
		end
		@(posedge clk); act <= 1'b1; settle();
		check("mon_adj_auto", {3'h0, mon}, 4'h1);
		$display("test adjust done");
		stop_test();
	end
endmodule // load_aware_watchdog_timer_test

`default_nettype wire

// *** rtl/lawdt_cfg.svh ***
`ifndef LAWDT_CFG_SVH
`define LAWDT_CFG_SVH

// System clock period
`define LAWDT_CLK_NS          10
// Charge and discharge phase lengths standing in for the timing capacitor
`define LAWDT_CHARGE_NS       2000
`define LAWDT_DISCHARGE_NS    2000
// Least times, rounded up to whole clock cycles
`define LAWDT_CHARGE_CYC      ((`LAWDT_CHARGE_NS + `LAWDT_CLK_NS - 1) / `LAWDT_CLK_NS)
`define LAWDT_DISCHARGE_CYC   ((`LAWDT_DISCHARGE_NS + `LAWDT_CLK_NS - 1) / `LAWDT_CLK_NS)
// Untriggered cycles before a timeout
`define LAWDT_TIMEOUT_CYCLES  3'h4
// Cycles held low after a timeout
`define LAWDT_LOW_CYCLES      3'h1

// Bit positions in the synchronised pin vector
`define LAWDT_PIN_ENABLE      0
`define LAWDT_PIN_TRIGGER     1
`define LAWDT_PIN_ADJ0        2
`define LAWDT_PIN_ADJ1        3
`define LAWDT_PIN_ACT_HIGH    4
`define LAWDT_PIN_DEACT_LOW   5
`define LAWDT_PIN_VIN_OK      6
`define LAWDT_PIN_VOUT_REL    7
`define LAWDT_PIN_VOUT_DET    8
`define LAWDT_PIN_RESET_OUT   9
`define LAWDT_PIN_COUNT       10

// Adjust pin status codes
`define LAWDT_ADJ_LOW         2'h0
`define LAWDT_ADJ_HIGH        2'h1

// Reset values
`define LAWDT_RST_WDO         1'b1
`define LAWDT_RST_COMBINED    1'b0

`endif

// *** rtl/lawdt_pkg.sv ***
package lawdt_pkg;

	typedef enum logic [1:0] {
		LAWDT_IDLE,
		LAWDT_CHARGE,
		LAWDT_DISCHARGE
	} lawdt_phase_t;

	typedef enum logic [1:0] {
		LAWDT_MODE_UNUSED,
		LAWDT_MODE_ALWAYS,
		LAWDT_MODE_AUTO
	} lawdt_adj_mode_t;

	typedef struct packed {
		lawdt_phase_t phase;
		logic [11:0]  cnt;
		logic [2:0]   cycles;
		logic         wdo;
		logic         load_flag;
		logic         trig_prev;
		logic         mon;
		logic         combined;
	} lawdt_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic val;
	} lawdt_sync_state_t;

endpackage

// *** rtl/lawdt_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module lawdt_sync (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic pin_in,
	output logic      pin_out
);
	import lawdt_pkg::*;

	lawdt_sync_state_t st_reg;
	lawdt_sync_state_t st_next;

	// Three stages; value moves only once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.val = st_reg.s3;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pin_out = st_reg.val;

endmodule // lawdt_sync

`default_nettype wire

// *** rtl/lawdt_top.sv ***
//Contract
// - Enable low disables watchdog, stops current detection and monitoring.
// - Enable high lets monitoring run under the other activation conditions.
// - Enable input pulled down; floating enable reads low, watchdog disabled.
// - Monitor only with enable, load flag high and output voltage released; with the adjust pin high the code monitors with the load flag low.
// - Load flag sets at activation current or above, clears at deactivation or below.
// - After deactivation, stay off until current reaches activation threshold.
// - Current detection stops while input supply is below its minimum.
// - Adjust pin: low unused, high always active, open autonomous.
// - Trigger rising edge during monitoring starts a charge phase.
// - Charge phase turns to discharge at the upper timing threshold.
// - Trigger during a cycle restarts it; watchdog output stays high.
// - Four untriggered cycles in a row drive watchdog output low.
// - Deactivation while output high clears the completed-cycle count.
// - After timeout, one low cycle, then high again and cycling resumes.
// - Deactivation while output low still holds low until cycle ends.
// - Trigger input pulled down; floating trigger reads low.
// - Triggers taken only when monitoring, output high and cycle running.
// - Combined pin is the AND of reset output and watchdog output.
`timescale 1ns/100ps
`default_nettype none
`include "lawdt_cfg.svh"

module lawdt_top #(
	parameter int CHARGE_CYC    = `LAWDT_CHARGE_CYC,
	parameter int DISCHARGE_CYC = `LAWDT_DISCHARGE_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       watchdog_enable,
	input  wire logic       enable_pin_driven,
	input  wire logic       watchdog_trigger_input,
	input  wire logic       trigger_pin_driven,
	input  wire logic       adjust_variant,
	input  wire logic [1:0] activation_mode_adjust_pin,
	input  wire logic       activation_current_reached,
	input  wire logic       deactivation_current_reached,
	input  wire logic       input_supply_ok,
	input  wire logic       vout_at_release,
	input  wire logic       vout_at_detect,
	input  wire logic       reset_output,
	output logic            watchdog_output,
	output logic            combined_output,
	output logic            monitoring_active,
	output logic            load_current_flag,
	output lawdt_pkg::lawdt_phase_t timing_phase,
	output logic [2:0]      completed_cycles
);
	import lawdt_pkg::*;

	localparam logic [11:0] CHG_LAST = 12'(CHARGE_CYC - 1);
	localparam logic [11:0] DIS_LAST = 12'(DISCHARGE_CYC - 1);
	localparam logic [2:0]  TO_LAST  = `LAWDT_TIMEOUT_CYCLES - 3'h1;

	lawdt_state_t                st_reg;
	lawdt_state_t                st_next;
	logic [`LAWDT_PIN_COUNT-1:0] pin_raw;
	logic [`LAWDT_PIN_COUNT-1:0] pin_s;
	lawdt_adj_mode_t             adj_mode;
	logic                        enable_eff;
	logic                        activation;
	logic                        detect_en;
	logic                        monitor;
	logic                        trig_edge;
	logic                        trig_accept;
	logic                        charge_end;
	logic                        cycle_done;

	// Adjust pin status to mode; an open pin falls to autonomous
	function automatic lawdt_adj_mode_t lawdt_decode_adj(input logic [1:0] status);
		lawdt_adj_mode_t m;
		m = LAWDT_MODE_AUTO;
		if (status == `LAWDT_ADJ_LOW) begin
			m = LAWDT_MODE_UNUSED;
		end else if (status == `LAWDT_ADJ_HIGH) begin
			m = LAWDT_MODE_ALWAYS;
		end
		return m;
	endfunction

	// trigger pull-down
	// An undriven pin reads low before it reaches the synchroniser
	always_comb begin
		pin_raw = '0;
		pin_raw[`LAWDT_PIN_ENABLE]    = watchdog_enable & enable_pin_driven;
		pin_raw[`LAWDT_PIN_TRIGGER]   = watchdog_trigger_input & trigger_pin_driven;
		pin_raw[`LAWDT_PIN_ADJ0]      = activation_mode_adjust_pin[0];
		pin_raw[`LAWDT_PIN_ADJ1]      = activation_mode_adjust_pin[1];
		pin_raw[`LAWDT_PIN_ACT_HIGH]  = activation_current_reached;
		pin_raw[`LAWDT_PIN_DEACT_LOW] = deactivation_current_reached;
		pin_raw[`LAWDT_PIN_VIN_OK]    = input_supply_ok;
		pin_raw[`LAWDT_PIN_VOUT_REL]  = vout_at_release;
		pin_raw[`LAWDT_PIN_VOUT_DET]  = vout_at_detect;
		pin_raw[`LAWDT_PIN_RESET_OUT] = reset_output;
	end

	// Every pin crosses in; comparator outputs may chatter, so the agree filter helps
	genvar gi;
	generate
		for (gi = 0; gi < `LAWDT_PIN_COUNT; gi++) begin : g_sync
			lawdt_sync u_sync (
				.clk     (clk),
				.reset   (reset),
				.pin_in  (pin_raw[gi]),
				.pin_out (pin_s[gi])
			);
		end
	endgenerate

	// Mode selection and activation conditions
	always_comb begin
		adj_mode   = lawdt_decode_adj({pin_s[`LAWDT_PIN_ADJ1], pin_s[`LAWDT_PIN_ADJ0]});
		enable_eff = 1'b0;
		activation = 1'b0;
		detect_en  = 1'b0;
		if (adjust_variant) begin
			unique case (adj_mode)
				LAWDT_MODE_UNUSED: begin
					enable_eff = 1'b0;
					activation = 1'b0;
				end
				LAWDT_MODE_ALWAYS: begin
					enable_eff = 1'b1;
					activation = 1'b1;
				end
				LAWDT_MODE_AUTO: begin
					enable_eff = 1'b1;
					activation = st_reg.load_flag;
					detect_en  = pin_s[`LAWDT_PIN_VIN_OK];
				end
			endcase
		end else begin
			enable_eff = pin_s[`LAWDT_PIN_ENABLE];
			activation = st_reg.load_flag;
			detect_en  = pin_s[`LAWDT_PIN_ENABLE] & pin_s[`LAWDT_PIN_VIN_OK];
		end
		monitor = enable_eff & activation & pin_s[`LAWDT_PIN_VOUT_REL] & ~pin_s[`LAWDT_PIN_VOUT_DET];
	end

	// Timing cycle events
	always_comb begin
		trig_edge  = pin_s[`LAWDT_PIN_TRIGGER] & ~st_reg.trig_prev;
		charge_end = (st_reg.phase == LAWDT_CHARGE) && (st_reg.cnt == CHG_LAST);
		cycle_done = (st_reg.phase == LAWDT_DISCHARGE) && (st_reg.cnt == DIS_LAST);
		trig_accept = monitor & st_reg.wdo & (st_reg.phase != LAWDT_IDLE) & trig_edge;
	end

	// Next state of the watchdog
	always_comb begin
		st_next = st_reg;
		st_next.trig_prev = pin_s[`LAWDT_PIN_TRIGGER];
		st_next.mon       = monitor;

		if (!enable_eff) begin
			st_next.load_flag = 1'b0;
		end else if (detect_en) begin
			if (pin_s[`LAWDT_PIN_ACT_HIGH]) begin
				st_next.load_flag = 1'b1;
			end else if (pin_s[`LAWDT_PIN_DEACT_LOW]) begin
				st_next.load_flag = 1'b0;
			end
		end

		unique case (st_reg.phase)
			LAWDT_IDLE: begin
				st_next.cnt = 12'h000;
				if (monitor) begin
					st_next.phase = LAWDT_CHARGE;
				end
			end
			LAWDT_CHARGE: begin
				if (charge_end) begin
					st_next.cnt   = 12'h000;
					st_next.phase = LAWDT_DISCHARGE;
				end else begin
					st_next.cnt = st_reg.cnt + 12'h001;
				end
			end
			LAWDT_DISCHARGE: begin
				if (cycle_done) begin
					st_next.cnt   = 12'h000;
					st_next.phase = LAWDT_CHARGE;
					if (st_reg.wdo) begin
						if (st_reg.cycles == TO_LAST) begin
							st_next.wdo    = 1'b0;
							st_next.cycles = 3'h0;
						end else begin
							st_next.cycles = st_reg.cycles + 3'h1;
						end
					end else begin
						st_next.wdo    = 1'b1;
						st_next.cycles = 3'h0;
						if (!monitor) begin
							st_next.phase = LAWDT_IDLE;
						end
					end
				end else begin
					st_next.cnt = st_reg.cnt + 12'h001;
				end
			end
		endcase

		if (trig_accept) begin
			st_next.phase  = LAWDT_CHARGE;
			st_next.cnt    = 12'h000;
			st_next.cycles = 3'h0;
			// A trigger on the fourth cycle end beats the timeout
			st_next.wdo    = 1'b1;
		end

		if (!monitor && st_reg.wdo) begin
			st_next.phase  = LAWDT_IDLE;
			st_next.cnt    = 12'h000;
			st_next.cycles = 3'h0;
		end

		st_next.combined = pin_s[`LAWDT_PIN_RESET_OUT] & st_next.wdo;
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg           <= '0;
			st_reg.phase     <= LAWDT_IDLE;
			st_reg.wdo       <= `LAWDT_RST_WDO;
			st_reg.combined  <= `LAWDT_RST_COMBINED;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs all from the state register
	assign watchdog_output   = st_reg.wdo;
	assign combined_output   = st_reg.combined;
	assign monitoring_active = st_reg.mon;
	assign load_current_flag = st_reg.load_flag;
	assign timing_phase      = st_reg.phase;
	assign completed_cycles  = st_reg.cycles;

	// Disabled enable never yields monitoring
	property p_disable_off;
		@(posedge clk) disable iff (reset)
		(!adjust_variant && !pin_s[`LAWDT_PIN_ENABLE]) |=> (!monitoring_active && !load_current_flag);
	endproperty
	a_disable_off: assert property (p_disable_off) else $error("monitoring while disabled");

	// Low output voltage blocks monitoring
	property p_vout_low_off;
		@(posedge clk) disable iff (reset)
		pin_s[`LAWDT_PIN_VOUT_DET] |=> !monitoring_active;
	endproperty
	a_vout_low_off: assert property (p_vout_low_off) else $error("monitoring with output voltage low");

	// Activation current sets the flag
	property p_flag_set;
		@(posedge clk) disable iff (reset)
		(enable_eff && detect_en && pin_s[`LAWDT_PIN_ACT_HIGH]) |=> load_current_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("load flag not set");

	// Flag stays clear below activation
	property p_flag_hyst;
		@(posedge clk) disable iff (reset)
		(!load_current_flag && !pin_s[`LAWDT_PIN_ACT_HIGH]) |=> !load_current_flag;
	endproperty
	a_flag_hyst: assert property (p_flag_hyst) else $error("load flag set below activation");

	// Accepted trigger restarts the charge phase
	property p_trig_restart;
		@(posedge clk) disable iff (reset)
		trig_accept |=> (timing_phase == LAWDT_CHARGE && st_reg.cnt == 12'h000 && completed_cycles == 3'h0
			&& watchdog_output);
	endproperty
	a_trig_restart: assert property (p_trig_restart) else $error("trigger did not restart cycle");

	// Charge lasts its counted length then discharges
	property p_charge_len;
		@(posedge clk) disable iff (reset)
		(charge_end && !trig_accept && monitor) |=> (timing_phase == LAWDT_DISCHARGE && st_reg.cnt == 12'h000);
	endproperty
	a_charge_len: assert property (p_charge_len) else $error("charge did not end on count");

	// Fourth untriggered cycle drops the output
	property p_timeout;
		@(posedge clk) disable iff (reset)
		(cycle_done && watchdog_output && completed_cycles == 3'h3 && monitor && !trig_accept)
			|=> !watchdog_output;
	endproperty
	a_timeout: assert property (p_timeout) else $error("no timeout after four cycles");

	// Deactivation with output high clears count
	property p_deact_clear;
		@(posedge clk) disable iff (reset)
		(!monitor && watchdog_output) |=> (completed_cycles == 3'h0 && timing_phase == LAWDT_IDLE);
	endproperty
	a_deact_clear: assert property (p_deact_clear) else $error("count kept on deactivation");

	// Low phase holds through the charge and is still low at the discharge start
	property p_low_one;
		@(posedge clk) disable iff (reset)
		$fell(watchdog_output) |-> (timing_phase == LAWDT_CHARGE && !watchdog_output)
			##CHARGE_CYC (timing_phase == LAWDT_DISCHARGE && !watchdog_output);
	endproperty
	a_low_one: assert property (p_low_one) else $error("low cycle not counted");

	// Low output held until its cycle completes
	property p_low_hold;
		@(posedge clk) disable iff (reset)
		(!watchdog_output && !cycle_done) |=> !watchdog_output;
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low output released early");

	// Low output released once its cycle completes
	property p_low_release;
		@(posedge clk) disable iff (reset)
		(!watchdog_output && cycle_done) |=> watchdog_output;
	endproperty
	a_low_release: assert property (p_low_release) else $error("low output not released");

	// No trigger taken while output low; the phase count just runs on
	property p_trig_ignored;
		@(posedge clk) disable iff (reset)
		(!watchdog_output && trig_edge && !charge_end && !cycle_done && timing_phase != LAWDT_IDLE)
			|=> (timing_phase == $past(timing_phase) && st_reg.cnt == $past(st_reg.cnt) + 12'h001);
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("trigger taken with output low");

	// Combined pin never high while watchdog low
	property p_combined;
		@(posedge clk) disable iff (reset)
		combined_output |-> watchdog_output;
	endproperty
	a_combined: assert property (p_combined) else $error("combined pin high with watchdog low");

endmodule // lawdt_top

`default_nettype wire
